// ### design/cfb_burst_flash.sv
/*
  synchronous burst-read nor flash front end with word program, block erase and query.
  assumes pins arrive asynchronously and config_clock is well below half of clk.
*/
`default_nettype none

// Operation
// - 16-bit words follow the configuration clock with no wait states
// - ready/wait line held busy until the part can serve a burst
// - once ready, a burst can start at once with no setup commands
// - power-on lands directly in synchronous array read mode
// - after address latch, one word per rising clock edge from incrementing counter
// - start address captured at the latch edge before streaming
// - full 23-bit word address, random access to any word
// - array holds 8M words of 16 bits
// - 131 erasable blocks in sixteen 8 Mb banks
// - fifteen banks of uniform 64 Kword blocks
// - top bank: seven 64 Kword blocks then four 16 Kword blocks at top
// - erase whole blocks only, program one word at a time
// - common flash interface query reads are answered
// - data lines take commands in and drive read data out
module cfb_burst_flash #(
  parameter int MEM_BITS = cfb_pkg::ADDR_W,
  parameter int READY_CYCLES = cfb_pkg::READY_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire cfb_pkg::cfb_pins_t pins,
  output cfb_pkg::cfb_dq_drive_t dq_drive,
  output logic ready_wait_val,
  output logic ready_wait_en
);
  import cfb_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    cfb_pins_t s1;
    cfb_pins_t s2;
    logic clk_d;
    logic we_d;
    cfb_state_t st;
    cfb_mode_t mode;
    logic [ADDR_W-1:0] cnt;
    logic [ADDR_W-1:0] ptr;
    logic [ADDR_W-1:0] last;
    logic [15:0] timer;
    logic [DATA_W-1:0] dq_data;
    logic dq_oe;
    logic rw_oe;
  } cfb_regs_t;

  // synchroniser stages wake at pin idle levels, so no false select or edge follows reset
  localparam cfb_pins_t PINS_IDLE = '{chip_en_n: 1'b1, out_en_n: 1'b1, write_en_n: 1'b1, latch_en_n: 1'b1,
      hard_reset_n: 1'b1, default: '0};
  localparam cfb_regs_t REGS_RST = '{s1: PINS_IDLE, s2: PINS_IDLE, we_d: 1'b1, st: ST_POWERUP, mode: M_ARRAY,
      rw_oe: 1'b1, default: '0};

  cfb_regs_t r_reg;
  cfb_regs_t r_next;
  logic [DATA_W-1:0] mem [2**MEM_BITS];
  logic mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [DATA_W-1:0] mem_wd;
  logic clk_rise;
  logic we_rise;
  logic sel;
  logic rd;

  // ==========================================================
  // helpers
  function automatic logic [DATA_W-1:0] cfi_word(input logic [7:0] ofs);
    logic [DATA_W-1:0] w;
    w = '0;
    unique case (ofs)
      CFI_Q_OFS: w = CFI_Q;
      CFI_R_OFS: w = CFI_R;
      CFI_Y_OFS: w = CFI_Y;
      CFI_SIZE_OFS: w = CFI_SIZE;
      CFI_NREG_OFS: w = CFI_NREG;
      default: w = '0;
    endcase
    return w;
  endfunction : cfi_word

  function automatic logic [DATA_W-1:0] rd_word(input cfb_mode_t m, input logic [ADDR_W-1:0] a);
    return (m == M_QUERY) ? cfi_word(a[7:0]) : mem[a[MEM_BITS-1:0]];
  endfunction : rd_word

  // top 64 Kword slot splits into four 16 Kword parameter blocks
  function automatic logic [ADDR_W-1:0] blk_base(input logic [ADDR_W-1:0] a);
    return (a[22:16] == TOP_MAIN_IDX) ? {a[22:14], 14'h0000} : {a[22:16], 16'h0000};
  endfunction : blk_base

  function automatic logic [ADDR_W-1:0] blk_last(input logic [ADDR_W-1:0] a);
    return blk_base(a) | ((a[22:16] == TOP_MAIN_IDX) ? PAR_SPAN : MAIN_SPAN);
  endfunction : blk_last

  // ==========================================================
  // next state
  always_comb begin
    r_next = r_reg;
    // two-stage synchroniser: only s2 reads s1, all logic reads s2
    r_next.s1 = pins;
    r_next.s2 = r_reg.s1;
    r_next.clk_d = r_reg.s2.cfg_clk;
    r_next.we_d = r_reg.s2.write_en_n;
    clk_rise = r_reg.s2.cfg_clk & ~r_reg.clk_d;
    sel = ~r_reg.s2.chip_en_n;
    we_rise = r_reg.s2.write_en_n & ~r_reg.we_d & sel;
    rd = sel & ~r_reg.s2.out_en_n & r_reg.s2.write_en_n;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = '0;
    r_next.dq_oe = rd && (r_reg.st == ST_READY);
    unique case (r_reg.st)
      ST_POWERUP: begin
        r_next.mode = M_ARRAY;
        r_next.rw_oe = 1'b1;
        if (r_reg.timer == 16'(READY_CYCLES - 1)) begin
          r_next.st = ST_READY;
          r_next.rw_oe = 1'b0;
          r_next.timer = '0;
        end else begin
          r_next.timer = r_reg.timer + 16'h0001;
        end
      end
      ST_READY: begin
        if (sel && clk_rise && !r_reg.s2.latch_en_n) begin
          r_next.cnt = r_reg.s2.addr;
          r_next.dq_data = rd_word(r_reg.mode, r_reg.s2.addr);
        end else if (rd && clk_rise) begin
          r_next.cnt = r_reg.cnt + 23'h00_0001;
          r_next.dq_data = rd_word(r_reg.mode, r_reg.cnt + 23'h00_0001);
        end
        if (we_rise) begin
          unique case (r_reg.mode)
            M_PROG_SETUP: begin
              // flash programming can only clear bits
              mem_we = 1'b1;
              mem_wa = r_reg.s2.addr;
              mem_wd = r_reg.s2.dq & mem[r_reg.s2.addr[MEM_BITS-1:0]];
              r_next.mode = M_ARRAY;
            end
            M_ERASE_SETUP: begin
              r_next.mode = M_ARRAY;
              if (r_reg.s2.dq == CMD_CONFIRM) begin
                r_next.ptr = blk_base(r_reg.s2.addr);
                r_next.last = blk_last(r_reg.s2.addr);
                r_next.st = ST_ERASE;
                r_next.rw_oe = 1'b1;
              end
            end
            default: begin
              if (r_reg.s2.dq == CMD_PROGRAM) begin
                r_next.mode = M_PROG_SETUP;
              end else if (r_reg.s2.dq == CMD_ERASE) begin
                r_next.mode = M_ERASE_SETUP;
              end else if (r_reg.s2.dq == CMD_QUERY) begin
                r_next.mode = M_QUERY;
              end else begin
                r_next.mode = M_ARRAY;
              end
            end
          endcase
        end
      end
      ST_ERASE: begin
        // one word per clock keeps a single write port; the line stays busy meanwhile
        mem_we = 1'b1;
        mem_wa = r_reg.ptr;
        mem_wd = ERASED_WORD;
        r_next.ptr = r_reg.ptr + 23'h00_0001;
        if (r_reg.ptr == r_reg.last) begin
          r_next.st = ST_READY;
          r_next.rw_oe = 1'b0;
        end
      end
    endcase
    if (!r_reg.s2.hard_reset_n) begin
      r_next.st = ST_POWERUP;
      r_next.mode = M_ARRAY;
      r_next.timer = '0;
      r_next.rw_oe = 1'b1;
      r_next.dq_oe = 1'b0;
      mem_we = 1'b0;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= REGS_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // array has no reset; contents survive like nonvolatile storage
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_wa[MEM_BITS-1:0]] <= mem_wd;
    end
  end

  // ==========================================================
  // outputs
  assign dq_drive = '{data: r_reg.dq_data, oe: r_reg.dq_oe};
  assign ready_wait_val = 1'b0;
  assign ready_wait_en = r_reg.rw_oe;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence burst_edge;
    clk_rise && rd && r_reg.s2.latch_en_n && r_reg.st == ST_READY && !we_rise && r_reg.s2.hard_reset_n;
  endsequence

  sequence latch_edge;
    clk_rise && sel && !r_reg.s2.latch_en_n && r_reg.st == ST_READY && r_reg.s2.hard_reset_n;
  endsequence

  a_drive_gated: assert property (r_reg.dq_oe |-> !$past(pins.chip_en_n, 3) && !$past(pins.out_en_n, 3))
    else $error("data driven without select and output enable");
  a_ready_timing: assert property (r_reg.st == ST_POWERUP && r_reg.timer == 16'(READY_CYCLES - 1)
      && r_reg.s2.hard_reset_n |=> r_reg.st == ST_READY && !ready_wait_en)
    else $error("ready not signalled after power-up wait");
  a_powerup_mode: assert property ($rose(r_reg.st == ST_READY) && $past(r_reg.st) == ST_POWERUP
      |-> r_reg.mode == M_ARRAY)
    else $error("power-up did not land in array read");
  a_addr_latch: assert property (latch_edge |=> r_reg.cnt == $past(r_reg.s2.addr))
    else $error("start address not captured");
  a_burst_step: assert property (burst_edge |=> r_reg.cnt == $past(r_reg.cnt) + 23'h00_0001
      ##0 r_reg.dq_oe)
    else $error("burst counter did not advance");
  a_burst_nowait: assert property (burst_edge ##1 1'b1 |-> !ready_wait_en)
    else $error("wait inserted during burst");
  a_erase_span: assert property ($rose(r_reg.st == ST_ERASE) |-> (r_reg.last - r_reg.ptr == MAIN_SPAN
      || r_reg.last - r_reg.ptr == PAR_SPAN) && r_reg.ptr[22:19] == r_reg.last[22:19])
    else $error("erase span is not one block");
  a_erase_done: assert property (r_reg.st == ST_ERASE && r_reg.ptr == r_reg.last && r_reg.s2.hard_reset_n
      |=> r_reg.st == ST_READY && !r_reg.rw_oe)
    else $error("erase did not finish at block end");
  a_query_sig: assert property (latch_edge and (r_reg.mode == M_QUERY && r_reg.s2.addr[7:0] == CFI_Q_OFS)
      |=> r_reg.dq_data == CFI_Q)
    else $error("query signature missing");

  // ==========================================================
  // power-up, pin reset and ready line
  // checks read s2, so they see the pins two clocks late
  a_powerup_busy: assert property (r_reg.st == ST_POWERUP |-> ready_wait_en)
    else $error("ready line released during power-up wait");
  a_timer_bound: assert property (r_reg.st == ST_POWERUP |-> r_reg.timer < 16'(READY_CYCLES))
    else $error("power-up timer ran past its limit");
  a_pin_reset: assert property (!r_reg.s2.hard_reset_n |=> r_reg.st == ST_POWERUP && r_reg.mode == M_ARRAY
      && ready_wait_en && !r_reg.dq_oe)
    else $error("reset pin did not return to power-up wait");
  a_ready_hold: assert property (r_reg.st == ST_READY && !we_rise && r_reg.s2.hard_reset_n
      |=> !ready_wait_en)
    else $error("ready line went busy with no command");
  a_oe_refused: assert property (r_reg.st != ST_READY |=> !r_reg.dq_oe)
    else $error("data driven while busy");

  // ==========================================================
  // program, erase and query commands
  sequence prog_edge;
    we_rise && r_reg.st == ST_READY && r_reg.mode == M_PROG_SETUP && r_reg.s2.hard_reset_n;
  endsequence

  sequence cancel_edge;
    we_rise && r_reg.st == ST_READY && r_reg.mode == M_ERASE_SETUP && r_reg.s2.dq != CMD_CONFIRM
      && r_reg.s2.hard_reset_n;
  endsequence

  // programming only clears bits, so the written word holds no bit the data lacks
  a_prog_clear: assert property (prog_edge |-> mem_we && mem_wa == r_reg.s2.addr
      && (mem_wd & ~r_reg.s2.dq) == '0)
    else $error("program set a bit that the data does not hold");
  a_prog_done: assert property (prog_edge |=> r_reg.mode == M_ARRAY && r_reg.st == ST_READY)
    else $error("program setup not left after one word");
  a_erase_cancel: assert property (cancel_edge |=> r_reg.st == ST_READY && r_reg.mode == M_ARRAY)
    else $error("erase started without confirm");
  a_erase_write: assert property (r_reg.st == ST_ERASE && r_reg.s2.hard_reset_n
      |-> mem_we && mem_wa == r_reg.ptr && mem_wd == ERASED_WORD)
    else $error("erase step did not clear a word");
  a_erase_walk: assert property (r_reg.st == ST_ERASE && r_reg.ptr != r_reg.last && r_reg.s2.hard_reset_n
      |=> r_reg.st == ST_ERASE && r_reg.ptr == $past(r_reg.ptr) + 23'h00_0001)
    else $error("erase pointer did not step");
  a_param_top: assert property ($rose(r_reg.st == ST_ERASE) && r_reg.last - r_reg.ptr == PAR_SPAN
      |-> r_reg.ptr[22:16] == TOP_MAIN_IDX)
    else $error("small block erased outside the top slot");
  a_cmd_query: assert property (we_rise && r_reg.st == ST_READY && r_reg.s2.hard_reset_n
      && (r_reg.mode == M_ARRAY || r_reg.mode == M_QUERY) && r_reg.s2.dq == CMD_QUERY
      |=> r_reg.mode == M_QUERY)
    else $error("query command not taken");

endmodule : cfb_burst_flash

`default_nettype wire

// ### design/cfb_pkg.sv
/*
  shared constants and carrier types for the configuration flash burst-read block.
  assumes a single 25 mhz system clock; all flash pins arrive asynchronously.
*/
`default_nettype none

package cfb_pkg;

  // ==========================================================
  // geometry
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int BANK_SH = 19;
  localparam int MAIN_SH = 16;
  localparam int PAR_SH = 14;
  localparam int N_BANKS = 16;
  localparam int N_BLOCKS = 131;
  localparam logic [6:0] TOP_MAIN_IDX = 7'h7f;
  localparam logic [ADDR_W-1:0] MAIN_SPAN = 23'h00_ffff;
  localparam logic [ADDR_W-1:0] PAR_SPAN = 23'h00_3fff;

  // ==========================================================
  // timing
  localparam int CLK_NS = 40;
  localparam int CFG_MAX_MHZ = 50;
  localparam int T_READY_NS = 1000;
  localparam int READY_CYC = (T_READY_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================
  // command words and data values
  localparam logic [DATA_W-1:0] CMD_READ_ARRAY = 16'h00ff;
  localparam logic [DATA_W-1:0] CMD_QUERY = 16'h0098;
  localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h0040;
  localparam logic [DATA_W-1:0] CMD_ERASE = 16'h0020;
  localparam logic [DATA_W-1:0] CMD_CONFIRM = 16'h00d0;
  localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;

  // ==========================================================
  // query table
  localparam logic [7:0] CFI_Q_OFS = 8'h10;
  localparam logic [7:0] CFI_R_OFS = 8'h11;
  localparam logic [7:0] CFI_Y_OFS = 8'h12;
  localparam logic [7:0] CFI_SIZE_OFS = 8'h27;
  localparam logic [7:0] CFI_NREG_OFS = 8'h2c;
  localparam logic [DATA_W-1:0] CFI_Q = 16'h0051;
  localparam logic [DATA_W-1:0] CFI_R = 16'h0052;
  localparam logic [DATA_W-1:0] CFI_Y = 16'h0059;
  localparam logic [DATA_W-1:0] CFI_SIZE = 16'h0018;
  localparam logic [DATA_W-1:0] CFI_NREG = 16'h0002;

  // ==========================================================
  // types
  typedef struct packed {
    logic cfg_clk;
    logic chip_en_n;
    logic out_en_n;
    logic write_en_n;
    logic latch_en_n;
    logic hard_reset_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
  } cfb_pins_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic oe;
  } cfb_dq_drive_t;

  typedef enum logic [1:0] {ST_POWERUP, ST_READY, ST_ERASE} cfb_state_t;
  typedef enum logic [1:0] {M_ARRAY, M_QUERY, M_PROG_SETUP, M_ERASE_SETUP} cfb_mode_t;

endpackage : cfb_pkg

`default_nettype wire

// ### sim/cfb_cfg_host.sv
/*
  model of the parallel configuration port that bursts from the flash block.
  assumes the bench clock clk and an open-drain ready/wait wire with pull-up.
*/
`default_nettype none

module cfb_cfg_host (
  input wire logic clk,
  input wire logic ready_wait,
  output cfb_pkg::cfb_pins_t pins
);
  import cfb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // pin idle levels: clock stands low outside frames, addr pulled down
  initial begin
    pins = '0;
    pins.chip_en_n = 1'b1;
    pins.out_en_n = 1'b1;
    pins.write_en_n = 1'b1;
    pins.latch_en_n = 1'b1;
    pins.hard_reset_n = 1'b1;
    pins.dq = 16'ha5a5;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // ==========================================================
  // command write, data released to its inverse afterwards
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    pins.addr = a;
    pins.dq = d;
    pins.chip_en_n = 1'b0;
    pins.write_en_n = 1'b0;
    tick(4);
    pins.write_en_n = 1'b1;
    tick(4);
    pins.chip_en_n = 1'b1;
    pins.dq = ~d;
    pins.addr = '0;
    tick(2);
  endtask : wr

  // bounded wait for the released ready/wait line
  task automatic wait_ready(input int lim, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < lim && !ok; i++) begin
      tick(1);
      ok = ready_wait;
    end
  endtask : wait_ready

  // one config_clock period of 320 ns; latch low only on the first rise
  task automatic step(input logic lat_n);
    pins.latch_en_n = lat_n;
    tick(1);
    pins.cfg_clk = 1'b1;
    tick(4);
    pins.cfg_clk = 1'b0;
    tick(3);
  endtask : step

  task automatic start(input logic [ADDR_W-1:0] a, input logic oe_n);
    pins.addr = a;
    pins.chip_en_n = 1'b0;
    pins.out_en_n = oe_n;
    step(1'b0);
    pins.latch_en_n = 1'b1;
    pins.addr = '0;
  endtask : start

  task automatic stop();
    pins.out_en_n = 1'b1;
    pins.chip_en_n = 1'b1;
    tick(4);
  endtask : stop
endmodule : cfb_cfg_host

`default_nettype wire

// ### sim/cfb_burst_flash_bench.sv
/*
  self-checking bench for cfb_burst_flash: erase, program, bursts, query, pin reset.
  assumes the array is narrowed to 17 address bits so the model memory stays small.
*/
`default_nettype none

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end

module cfb_burst_flash_bench;
  import cfb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk;
  logic rst;
  logic ok;
  logic ready_wait;
  logic ready_wait_val;
  logic ready_wait_en;
  logic [15:0] lfsr_reg;
  logic [DATA_W-1:0] mem [0:15];
  int fails;
  int total_checks;
  cfb_pins_t pins;
  cfb_dq_drive_t dq_drive;

  // ==========================================================
  // clock, wire resolution, instances
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  assign ready_wait = ready_wait_en ? ready_wait_val : 1'b1;

  cfb_cfg_host host (.clk(clk), .ready_wait(ready_wait), .pins(pins));

  cfb_burst_flash #(.MEM_BITS(17), .READY_CYCLES(4)) DUT (
    .clk(clk), .rst(rst), .pins(pins), .dq_drive(dq_drive),
    .ready_wait_val(ready_wait_val), .ready_wait_en(ready_wait_en));

  // ==========================================================
  // expectation helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next

  function automatic logic [DATA_W-1:0] qry_word(input logic [ADDR_W-1:0] a);
    case (a[7:0])
      CFI_Q_OFS: return CFI_Q;
      CFI_R_OFS: return CFI_R;
      CFI_Y_OFS: return CFI_Y;
      CFI_SIZE_OFS: return CFI_SIZE;
      CFI_NREG_OFS: return CFI_NREG;
      default: return 16'h0000;
    endcase
  endfunction : qry_word

  // burst of n words from a; each word checked before the next rise
  task automatic burst(input logic [ADDR_W-1:0] a, input int n, input logic qry);
    host.start(a, 1'b0);
    for (int i = 0; i < n; i++) begin
      `CHK("oe", 1'b1, dq_drive.oe)
      `CHK("word", qry ? qry_word(a + 23'(i)) : mem[a + i], dq_drive.data)
      host.step(1'b1);
    end
    host.stop();
  endtask : burst

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    // both erases plus a few thousand cycles of bursts and commands
    #((int'(MAIN_SPAN) + int'(PAR_SPAN) + 8000) * 40);
    fails++;
    complete_run();
  end

  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    fails = 0;
    total_checks = 0;
    lfsr_reg = 16'h004c;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    `CHK("busy_after_reset", 1'b1, ready_wait_en)
    host.wait_ready(100, ok);
    `CHK("ready_seen", 1'b1, ok)
    // burst straight after ready, no commands first
    host.start('0, 1'b0);
    `CHK("oe_first_burst", 1'b1, dq_drive.oe)
    host.stop();
    `CHK("oe_released", 1'b0, dq_drive.oe)
    // whole-block erase of block zero
    host.wr('0, CMD_ERASE);
    host.wr('0, CMD_CONFIRM);
    `CHK("busy_erase", 1'b1, ready_wait_en)
    `CHK("wait_low", 1'b0, ready_wait)
    host.wait_ready(65000, ok);
    `CHK("erase_early", 1'b0, ok)
    host.wait_ready(1000, ok);
    `CHK("erase_done", 1'b1, ok)
    // erase setup followed by anything but confirm is dropped
    host.wr('0, CMD_ERASE);
    host.wr('0, CMD_READ_ARRAY);
    `CHK("erase_cancel", 1'b0, ready_wait_en)
    foreach (mem[i]) mem[i] = ERASED_WORD;
    // program random words; word 0 twice to see the AND of old and new
    for (int i = -1; i < 12; i++) begin
      lfsr_reg = lfsr_next(lfsr_reg);
      host.wr(23'(i < 0 ? 0 : i), CMD_PROGRAM);
      host.wr(23'(i < 0 ? 0 : i), lfsr_reg);
      mem[i < 0 ? 0 : i] = mem[i < 0 ? 0 : i] & lfsr_reg;
    end
    host.wr('0, CMD_READ_ARRAY);
    burst('0, 14, 1'b0);
    burst(23'h00_0005, 3, 1'b0);
    // output enable high keeps the lines released
    host.start('0, 1'b1);
    host.step(1'b1);
    `CHK("oe_gated", 1'b0, dq_drive.oe)
    host.stop();
    // query table reads, then back to array read
    host.wr('0, CMD_QUERY);
    burst({15'h0, CFI_Q_OFS}, 3, 1'b1);
    burst({15'h0, CFI_SIZE_OFS}, 1, 1'b1);
    burst({15'h0, CFI_NREG_OFS}, 1, 1'b1);
    host.wr('0, CMD_READ_ARRAY);
    burst('0, 2, 1'b0);
    // top slot holds the small blocks: a quarter of the main erase time
    host.wr(23'h7f_c000, CMD_ERASE);
    host.wr(23'h7f_c000, CMD_CONFIRM);
    host.wait_ready(16000, ok);
    `CHK("param_early", 1'b0, ok)
    host.wait_ready(1000, ok);
    `CHK("param_done", 1'b1, ok)
    // pin reset returns to power-up wait and then array read
    host.pins.hard_reset_n = 1'b0;
    host.tick(4);
    `CHK("busy_pin_reset", 1'b1, ready_wait_en)
    host.pins.hard_reset_n = 1'b1;
    host.wait_ready(100, ok);
    `CHK("ready_again", 1'b1, ok)
    burst('0, 4, 1'b0);
    complete_run();
  end
endmodule : cfb_burst_flash_bench

`default_nettype wire
